//--- design/thcp_device.sv
// data control end: host command qualify, status drive, mode lines, servo link
`timescale 1ns/1ns
`default_nettype none
module thcp_device (
  input  wire logic        clock,
  input  wire logic        rst_b,
  input  wire logic        clock_en,
  thcp_link_if.device      link,
  input  wire logic [3:0]  sw_addr,
  input  wire logic [15:0] sw_wdata,
  input  wire logic        sw_write,
  input  wire logic        sw_read,
  output logic      [15:0] sw_rdata,
  input  wire logic        tape_start_marker
);
  import thcp_pkg::*;

  // ----------------------------------------------------------------
  // reset interlock
  // ----------------------------------------------------------------
  logic healthy_s1, healthy_s2;
  // hold device side until data processor healthy
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      healthy_s1 <= 1'b0;
      healthy_s2 <= 1'b0;
    end else if (clock_en) begin
      healthy_s1 <= link.data_processor_healthy;
      healthy_s2 <= healthy_s1;
    end
  end
  logic run;
  assign run = clock_en && healthy_s2;

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  logic [11:0] pin_raw, pin_s1, pin_s2;
  assign pin_raw = {link.host_command_strobe, link.host_interface_enable,
                    link.host_formatter_address, link.host_transport_address_1,
                    link.host_transport_address_0, link.cmd_reverse_line,
                    link.cmd_write_line, link.cmd_filemark_line, link.cmd_edit_line,
                    link.cmd_erase_line, link.spare_host_line, tape_start_marker};
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      pin_s1 <= 12'h000;
      pin_s2 <= 12'h000;
    end else if (clock_en) begin
      pin_s1 <= pin_raw;
      pin_s2 <= pin_s1;
    end
  end
  logic       strobe_s, enable_s, at_start;
  logic [2:0] addr_s;
  logic [5:0] cmd_lines_s;
  assign strobe_s    = pin_s2[11];
  assign enable_s    = pin_s2[10];
  assign addr_s      = pin_s2[9:7];
  assign cmd_lines_s = pin_s2[6:1];
  assign at_start    = pin_s2[0];

  // ----------------------------------------------------------------
  // software registers
  // ----------------------------------------------------------------
  logic [15:0] ctrl, config_store;
  logic [7:0]  host_out, servo_tx;
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      ctrl         <= CTRL_RESET;
      config_store <= CONFIG_RESET;
      host_out     <= HOSTOUT_RESET;
    end else if (clock_en && sw_write) begin
      unique case (sw_addr)
        REG_CTRL:    ctrl <= sw_wdata;
        REG_CONFIG:  config_store <= sw_wdata;
        REG_HOSTOUT: host_out <= sw_wdata[7:0];
        default: ;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // unit select and enable flip-flop
  // ----------------------------------------------------------------
  logic selected, if_enabled;
  // address and enable feed dedicated logic
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      selected   <= 1'b0;
      if_enabled <= 1'b0;
    end else if (run) begin
      selected   <= (addr_s == ctrl[CTRL_ADDR0 +: 3]);
      if_enabled <= enable_s;
    end
  end

  // ----------------------------------------------------------------
  // command strobe qualify
  // ----------------------------------------------------------------
  logic       strobe_d, new_cmd;
  logic [5:0] cmd_latched;
  logic       edge_hit;
  // edge choice and select qualify strobe
  assign edge_hit = ctrl[CTRL_EDGE] ? (!strobe_s && strobe_d) : (strobe_s && !strobe_d);
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      strobe_d    <= 1'b0;
      new_cmd     <= 1'b0;
      cmd_latched <= 6'h00;
    end else if (run) begin
      strobe_d <= strobe_s;
      // adapter commands enter the same path
      if (edge_hit && selected && if_enabled) begin
        new_cmd     <= 1'b1;
        cmd_latched <= cmd_lines_s;
      end else if (sw_write && sw_addr == REG_CTRL && sw_wdata[CTRL_ACK]) begin
        new_cmd <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // mode lines
  // ----------------------------------------------------------------
  // only listed codes produced
  function automatic logic [3:0] mode_code(input logic [1:0] dens, input logic hi);
    unique case (dens)
      DENS_NRZ:    mode_code = hi ? MODE_NRZ_HI : MODE_NRZ_LO;
      DENS_GCR:    mode_code = hi ? MODE_GCR_HI : MODE_GCR_LO;
      DENS_PE3200: mode_code = MODE_PE32_LO;
      default:     mode_code = hi ? MODE_PE16_HI : MODE_PE16_LO;
    endcase
  endfunction : mode_code

  logic [3:0] mode;
  logic [1:0] density;
  // mode updated directly on REG_MODE write; CTRL_APPLY bit not used
  // density only moves at tape start
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      mode    <= MODE_RESET;
      density <= DENS_PE1600;
    end else if (run && sw_write && sw_addr == REG_MODE) begin
      if (at_start) begin
        density <= sw_wdata[2:1];
        mode    <= mode_code(sw_wdata[2:1], sw_wdata[0]);
      end else begin
        mode    <= mode_code(density, sw_wdata[0]);
      end
    end
  end
  assign link.density_nrz_flag         = mode[3];
  assign link.density_group_coded_flag = mode[2];
  assign link.density_3200_flag        = mode[1];
  assign link.speed_select_flag        = mode[0];

  // ----------------------------------------------------------------
  // host status outputs
  // ----------------------------------------------------------------
  logic online_n, speed_n, status_oe;
  logic [7:0] status_n;
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      online_n  <= 1'b1;
      speed_n   <= 1'b1;
      status_n  <= 8'hff;
      status_oe <= 1'b0;
    end else if (clock_en) begin
      online_n  <= !(selected && healthy_s2);
      // 3200 density counts as high speed
      speed_n   <= !(mode[0] || mode[1]);
      status_n  <= ~host_out;
      status_oe <= selected && healthy_s2;
    end
  end
  assign link.online_status_out = online_n;
  assign link.speed_status_out  = speed_n;
  assign link.host_status_n     = status_n;
  assign link.host_status_oe    = status_oe;

  // ----------------------------------------------------------------
  // servo link byte exchange
  // ----------------------------------------------------------------
  thcp_servo_state_e sv_state;
  logic [2:0] sv_cnt;
  logic       sv_which;
  logic [7:0] servo_rx;
  logic       sv_wr, sv_rda, sv_rdb, sv_oe;
  // strobed byte exchange, single byte register on far side
  // spare messages travel as ordinary bytes
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      sv_state <= THCP_SV_IDLE;
      sv_cnt   <= 3'h0;
      sv_which <= 1'b0;
      servo_tx <= SERVO_RESET;
      servo_rx <= SERVO_RESET;
      sv_wr    <= 1'b0;
      sv_rda   <= 1'b0;
      sv_rdb   <= 1'b0;
      sv_oe    <= 1'b0;
    end else if (run) begin
      unique case (sv_state)
        THCP_SV_IDLE: begin
          if (sw_write && sw_addr == REG_SERVO_TX) begin
            servo_tx <= sw_wdata[7:0];
            sv_oe    <= 1'b1;
            sv_wr    <= 1'b1;
            sv_cnt   <= SERVO_ACCESS_CYCLES;
            sv_state <= THCP_SV_WRITE;
          end else if (sw_write && sw_addr == REG_SERVO_RX) begin
            sv_which <= sw_wdata[0];
            sv_rda   <= !sw_wdata[0];
            sv_rdb   <= sw_wdata[0];
            sv_cnt   <= SERVO_ACCESS_CYCLES;
            sv_state <= THCP_SV_READ;
          end
        end
        THCP_SV_WRITE: begin
          sv_cnt <= sv_cnt - 3'h1;
          if (sv_cnt == 3'h1) begin
            sv_wr    <= 1'b0;
            sv_oe    <= 1'b0;
            sv_state <= THCP_SV_IDLE;
          end
        end
        THCP_SV_READ: begin
          sv_cnt <= sv_cnt - 3'h1;
          if (sv_cnt == 3'h1) begin
            servo_rx <= link.servo_link_bus;
            sv_rda   <= 1'b0;
            sv_rdb   <= 1'b0;
            sv_state <= THCP_SV_IDLE;
          end
        end
      endcase
    end
  end
  assign link.servo_bus_dev_out       = servo_tx;
  assign link.servo_bus_dev_oe        = sv_oe;
  assign link.servo_link_write_strobe = sv_wr;
  assign link.servo_link_read_strobe_a = sv_rda;
  assign link.servo_link_read_strobe_b = sv_rdb;

  // ----------------------------------------------------------------
  // read port
  // ----------------------------------------------------------------
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      sw_rdata <= 16'h0000;
    end else if (clock_en) begin
      sw_rdata <= 16'h0000;
      if (sw_read) begin
        unique case (sw_addr)
          REG_CTRL:     sw_rdata <= ctrl;
          REG_STATUS:   sw_rdata <= {8'h00, sv_which, !sv_state[0], at_start,
                                     if_enabled, selected, healthy_s2, new_cmd, 1'b0};
          REG_COMMAND:  sw_rdata <= {10'h000, cmd_latched};
          REG_MODE:     sw_rdata <= {12'h000, mode};
          REG_HOSTOUT:  sw_rdata <= {8'h00, host_out};
          REG_SERVO_TX: sw_rdata <= {8'h00, servo_tx};
          REG_SERVO_RX: sw_rdata <= {8'h00, servo_rx};
          REG_CONFIG:   sw_rdata <= config_store;
          default:      sw_rdata <= 16'h0000;
        endcase
      end
    end
  end
endmodule : thcp_device
`default_nettype wire

//--- design/thcp_far_end.sv
// host controller and servo side end driving the link from a user port
`timescale 1ns/1ns
`default_nettype none
module thcp_far_end (
  input  wire logic       clock,
  input  wire logic       rst_b,
  input  wire logic       clock_en,
  thcp_link_if.far        link,
  input  wire logic       user_healthy,
  input  wire logic       user_enable,
  input  wire logic [2:0] user_address,
  input  wire logic [5:0] user_command,
  input  wire logic       user_go,
  input  wire logic [7:0] user_servo_byte,
  output logic      [7:0] user_servo_rx,
  output logic            user_rx_valid,
  output logic            user_online
);
  import thcp_pkg::*;

  // ----------------------------------------------------------------
  // host command drive
  // ----------------------------------------------------------------
  logic       go, en, healthy;
  logic [2:0] addr;
  logic [5:0] cmd;
  logic       wr_d, rx_v, online_s1, online_s2;
  logic [7:0] rx;
  // commands presented as ordinary host lines
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      go      <= 1'b0;
      en      <= 1'b0;
      healthy <= 1'b0;
      addr    <= 3'h0;
      cmd     <= 6'h00;
    end else if (clock_en) begin
      healthy <= user_healthy;
      en   <= user_enable;
      addr <= user_address;
      if (!user_go) cmd <= user_command;
      go   <= user_go;
    end
  end
  assign link.host_command_strobe      = go;
  assign link.host_interface_enable    = en;
  assign link.data_processor_healthy   = healthy;
  assign {link.host_formatter_address, link.host_transport_address_1,
          link.host_transport_address_0} = addr;
  // spare line rides with unallocated codes
  assign {link.cmd_reverse_line, link.cmd_write_line, link.cmd_filemark_line,
          link.cmd_edit_line, link.cmd_erase_line, link.spare_host_line} = cmd;

  // ----------------------------------------------------------------
  // servo side byte exchange
  // ----------------------------------------------------------------
  // answer read strobes, capture on write strobe
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      wr_d      <= 1'b0;
      rx        <= 8'h00;
      rx_v      <= 1'b0;
      online_s1 <= 1'b0;
      online_s2 <= 1'b0;
    end else if (clock_en) begin
      wr_d <= link.servo_link_write_strobe;
      rx_v <= 1'b0;
      // byte taken at strobe start: drive and strobe drop on one edge
      if (link.servo_link_write_strobe && !wr_d) begin
        rx <= link.servo_link_bus;
      end
      if (wr_d && !link.servo_link_write_strobe) begin
        rx_v <= 1'b1;
      end
      online_s1 <= !link.online_status_out;
      online_s2 <= online_s1;
    end
  end
  assign link.servo_bus_far_out = user_servo_byte;
  assign link.servo_bus_far_oe  = link.servo_link_read_strobe_a ||
                                  link.servo_link_read_strobe_b;
  assign user_servo_rx = rx;
  assign user_rx_valid = rx_v;
  assign user_online   = online_s2;
endmodule : thcp_far_end
`default_nettype wire

//--- design/thcp_link_if.sv
// wires between the data control end and the host/servo end
`timescale 1ns/1ns
`default_nettype none
interface thcp_link_if;
  // host command lines
  logic       host_command_strobe;
  logic       host_interface_enable;
  logic       host_formatter_address;
  logic       host_transport_address_0;
  logic       host_transport_address_1;
  logic       cmd_reverse_line;
  logic       cmd_write_line;
  logic       cmd_filemark_line;
  logic       cmd_edit_line;
  logic       cmd_erase_line;
  logic       spare_host_line;
  // host status lines, active low as on the bus except active-high host_status_oe
  logic       online_status_out;
  logic       speed_status_out;
  logic [7:0] host_status_n;
  logic       host_status_oe;
  // mode lines
  logic       density_nrz_flag;
  logic       density_group_coded_flag;
  logic       density_3200_flag;
  logic       speed_select_flag;
  // servo link
  logic       data_processor_healthy;
  logic [7:0] servo_bus_dev_out;
  logic       servo_bus_dev_oe;
  logic [7:0] servo_bus_far_out;
  logic       servo_bus_far_oe;
  logic [7:0] servo_link_bus;
  logic       servo_link_write_strobe;
  logic       servo_link_read_strobe_a;
  logic       servo_link_read_strobe_b;

  // resolved byte bus: whichever end enables drives it, device end first if both do
  assign servo_link_bus = servo_bus_dev_oe ? servo_bus_dev_out :
                          servo_bus_far_oe ? servo_bus_far_out : 8'hff;

  modport device (
    input  host_command_strobe, host_interface_enable, host_formatter_address,
    input  host_transport_address_0, host_transport_address_1,
    input  cmd_reverse_line, cmd_write_line, cmd_filemark_line,
    input  cmd_edit_line, cmd_erase_line, spare_host_line,
    output online_status_out, speed_status_out, host_status_n, host_status_oe,
    output density_nrz_flag, density_group_coded_flag, density_3200_flag,
    output speed_select_flag,
    input  data_processor_healthy, servo_link_bus,
    output servo_bus_dev_out, servo_bus_dev_oe,
    output servo_link_write_strobe, servo_link_read_strobe_a, servo_link_read_strobe_b
  );
  modport far (
    output host_command_strobe, host_interface_enable, host_formatter_address,
    output host_transport_address_0, host_transport_address_1,
    output cmd_reverse_line, cmd_write_line, cmd_filemark_line,
    output cmd_edit_line, cmd_erase_line, spare_host_line,
    input  online_status_out, speed_status_out, host_status_n, host_status_oe,
    input  density_nrz_flag, density_group_coded_flag, density_3200_flag,
    input  speed_select_flag,
    output data_processor_healthy, servo_bus_far_out, servo_bus_far_oe,
    input  servo_link_bus,
    input  servo_link_write_strobe, servo_link_read_strobe_a, servo_link_read_strobe_b
  );
endinterface : thcp_link_if
`default_nettype wire

//--- design/thcp_pkg.sv
// shared constants and types for the tape host command port
package thcp_pkg;
  // ----------------------------------------------------------------
  // mode codes: {density_nrz, group_coded, d3200, speed}
  // ----------------------------------------------------------------
  localparam logic [3:0] MODE_NRZ_LO   = 4'h8;
  localparam logic [3:0] MODE_NRZ_HI   = 4'h9;
  localparam logic [3:0] MODE_PE16_LO  = 4'h0;
  localparam logic [3:0] MODE_PE16_HI  = 4'h1;
  localparam logic [3:0] MODE_PE32_LO  = 4'h2;
  localparam logic [3:0] MODE_GCR_LO   = 4'h4;
  localparam logic [3:0] MODE_GCR_HI   = 4'h5;
  localparam logic [3:0] MODE_RESET    = MODE_PE16_LO;

  // density selector values
  localparam logic [1:0] DENS_PE1600 = 2'h0;
  localparam logic [1:0] DENS_NRZ    = 2'h1;
  localparam logic [1:0] DENS_GCR    = 2'h2;
  localparam logic [1:0] DENS_PE3200 = 2'h3;

  // ----------------------------------------------------------------
  // software port register map (word offsets)
  // ----------------------------------------------------------------
  localparam logic [3:0] REG_CTRL     = 4'h0;
  localparam logic [3:0] REG_STATUS   = 4'h1;
  localparam logic [3:0] REG_COMMAND  = 4'h2;
  localparam logic [3:0] REG_MODE     = 4'h3;
  localparam logic [3:0] REG_HOSTOUT  = 4'h4;
  localparam logic [3:0] REG_SERVO_TX = 4'h5;
  localparam logic [3:0] REG_SERVO_RX = 4'h6;
  localparam logic [3:0] REG_CONFIG   = 4'h7;

  // ctrl bit positions
  localparam int CTRL_EDGE   = 0;
  localparam int CTRL_ACK    = 1;
  localparam int CTRL_APPLY  = 2;
  localparam int CTRL_ADDR0  = 3;

  localparam logic [15:0] CTRL_RESET    = 16'h0000;
  localparam logic [15:0] CONFIG_RESET  = 16'h0000;
  localparam logic [7:0]  HOSTOUT_RESET = 8'h00;
  localparam logic [7:0]  SERVO_RESET   = 8'h00;

  // cycle count for one servo link access
  localparam logic [2:0] SERVO_ACCESS_CYCLES = 3'h3;

  typedef enum logic [2:0] {
    THCP_SV_IDLE  = 3'b001,
    THCP_SV_WRITE = 3'b010,
    THCP_SV_READ  = 3'b100
  } thcp_servo_state_e;
endpackage : thcp_pkg

//--- verification/tape_host_command_port_tb_top.sv
// testbench joining the device end and the far end
`timescale 1ns/1ns
`default_nettype none
module tape_host_command_port_tb_top;
  import thcp_pkg::*;
  logic clock, rst_b, tape_start_marker;
  logic [3:0] sw_addr;
  logic [15:0] sw_wdata, sw_rdata;
  logic sw_write, sw_read, user_healthy, user_enable, user_go;
  logic [2:0] user_address;
  logic [5:0] user_command;
  logic [7:0] user_servo_byte, user_servo_rx;
  logic user_rx_valid, user_online;
  int rx_pulses = 0;
  int failures, checks;
  logic [6:0] tab [7];

  thcp_link_if thcp_link_if_inst ();
  thcp_device thcp_device_inst (.clock(clock), .rst_b(rst_b), .clock_en(1'b1),
    .link(thcp_link_if_inst), .sw_addr(sw_addr), .sw_wdata(sw_wdata),
    .sw_write(sw_write), .sw_read(sw_read), .sw_rdata(sw_rdata),
    .tape_start_marker(tape_start_marker));
  thcp_far_end thcp_far_end_inst (.clock(clock), .rst_b(rst_b), .clock_en(1'b1),
    .link(thcp_link_if_inst), .user_healthy(user_healthy), .user_enable(user_enable),
    .user_address(user_address), .user_command(user_command), .user_go(user_go),
    .user_servo_byte(user_servo_byte), .user_servo_rx(user_servo_rx),
    .user_rx_valid(user_rx_valid), .user_online(user_online));
  thcp_chk thcp_chk_inst (.clock(clock), .rst_b(rst_b),
    .online_status_out(thcp_link_if_inst.online_status_out),
    .speed_status_out(thcp_link_if_inst.speed_status_out),
    .host_status_oe(thcp_link_if_inst.host_status_oe),
    .density_nrz_flag(thcp_link_if_inst.density_nrz_flag),
    .density_group_coded_flag(thcp_link_if_inst.density_group_coded_flag),
    .density_3200_flag(thcp_link_if_inst.density_3200_flag),
    .speed_select_flag(thcp_link_if_inst.speed_select_flag),
    .data_processor_healthy(thcp_link_if_inst.data_processor_healthy),
    .servo_bus_dev_oe(thcp_link_if_inst.servo_bus_dev_oe),
    .servo_link_write_strobe(thcp_link_if_inst.servo_link_write_strobe),
    .servo_link_read_strobe_a(thcp_link_if_inst.servo_link_read_strobe_a),
    .servo_link_read_strobe_b(thcp_link_if_inst.servo_link_read_strobe_b));

  // ----------------------------------------------------------------
  // bus tasks
  // ----------------------------------------------------------------
  task automatic cmp(input logic [15:0] g, input logic [15:0] e);
    checks++;
    if (g !== e) begin
      failures++;
      $display("mismatch at %0t: got %h expected %h", $time, g, e);
    end
  endtask : cmp
  task automatic idle(input int n);
    repeat (n) @(posedge clock);
  endtask : idle
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clock);
    sw_addr  <= a;
    sw_wdata <= d;
    sw_write <= 1'b1;
    @(posedge clock);
    sw_write <= 1'b0;
  endtask : wr
  // masked read, data stands only in the cycle after the strobe
  task automatic rd_chk(input logic [3:0] a, input logic [15:0] m, input logic [15:0] e);
    @(posedge clock);
    sw_addr <= a;
    sw_read <= 1'b1;
    @(posedge clock);
    sw_read <= 1'b0;
    #1 cmp(sw_rdata & m, e);
  endtask : rd_chk
  task automatic go(input logic v);
    @(posedge clock);
    user_go <= v;
    idle(8);
  endtask : go
  task automatic final_report;
    if (failures == 0 && checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : final_report

  // received-byte pulses seen at the far end
  always @(posedge clock) begin
    if (user_rx_valid === 1'b1) rx_pulses <= rx_pulses + 1;
  end
  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end
  initial begin
    repeat (4000) @(posedge clock);
    failures++;
    final_report();
  end

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    tab = '{{3'h0, MODE_PE16_LO}, {3'h1, MODE_PE16_HI}, {3'h6, MODE_PE32_LO},
            {3'h4, MODE_GCR_LO}, {3'h5, MODE_GCR_HI}, {3'h3, MODE_NRZ_HI},
            {3'h2, MODE_NRZ_LO}};
    {rst_b, tape_start_marker, sw_write, sw_read, user_healthy, user_enable, user_go} = '0;
    {sw_addr, sw_wdata, user_address, user_command, user_servo_byte} = '0;
    failures = 0;
    checks = 0;
    idle(8);
    rst_b <= 1'b1;
    idle(4);
    rd_chk(REG_STATUS, 16'h0004, 16'h0000);
    rd_chk(REG_MODE, 16'h000f, {12'h0, MODE_RESET});
    user_healthy <= 1'b1;
    idle(8);
    rd_chk(REG_STATUS, 16'h0004, 16'h0004);
    wr(REG_CTRL, 16'h0028);
    user_address <= 3'h5;
    idle(8);
    cmp(thcp_link_if_inst.online_status_out, 16'h0);
    rd_chk(REG_STATUS, 16'h0008, 16'h0008);
    cmp({15'h0, user_online}, 16'h0001);
    // strobe edges while host interface still disabled
    user_command <= 6'h2a;
    go(1'b1);
    go(1'b0);
    rd_chk(REG_STATUS, 16'h0002, 16'h0000);
    user_enable <= 1'b1;
    idle(8);
    go(1'b1);
    rd_chk(REG_STATUS, 16'h0002, 16'h0002);
    rd_chk(REG_COMMAND, 16'h003f, 16'h002a);
    wr(REG_CTRL, 16'h002b);
    rd_chk(REG_STATUS, 16'h0002, 16'h0000);
    go(1'b0);
    rd_chk(REG_STATUS, 16'h0002, 16'h0002);
    wr(REG_CTRL, 16'h002a);
    wr(REG_HOSTOUT, 16'h00a5);
    idle(4);
    cmp(thcp_link_if_inst.host_status_n, 16'h005a);
    cmp(thcp_link_if_inst.host_status_oe, 16'h1);
    wr(REG_CONFIG, 16'h5a3c);
    rd_chk(REG_CONFIG, 16'hffff, 16'h5a3c);
    // spare line with an unallocated code, entered like any host command
    user_command <= 6'h01;
    go(1'b1);
    rd_chk(REG_COMMAND, 16'h003f, 16'h0001);
    // every listed mode code, density free at tape start
    tape_start_marker <= 1'b1;
    idle(4);
    foreach (tab[i]) begin
      wr(REG_MODE, {13'h0, tab[i][6:4]});
      wr(REG_CTRL, 16'h002c);
      idle(4);
      rd_chk(REG_MODE, 16'h000f, {12'h0, tab[i][3:0]});
      cmp({thcp_link_if_inst.density_nrz_flag, thcp_link_if_inst.density_group_coded_flag,
           thcp_link_if_inst.density_3200_flag, thcp_link_if_inst.speed_select_flag},
          {12'h0, tab[i][3:0]});
      cmp(thcp_link_if_inst.speed_status_out, !(tab[i][0] | tab[i][1]));
    end
    // away from tape start only the speed may move
    tape_start_marker <= 1'b0;
    idle(4);
    wr(REG_MODE, 16'h0005);
    wr(REG_CTRL, 16'h002c);
    idle(4);
    rd_chk(REG_MODE, 16'h000f, {12'h0, MODE_NRZ_HI});
    wr(REG_SERVO_TX, 16'h003c);
    idle(8);
    cmp(user_servo_rx, 16'h003c);
    // second write lands while busy and is dropped
    wr(REG_SERVO_TX, 16'h0011);
    wr(REG_SERVO_TX, 16'h0022);
    idle(8);
    cmp(user_servo_rx, 16'h0011);
    cmp(16'(rx_pulses), 16'h0002);
    user_servo_byte <= 8'hc3;
    wr(REG_SERVO_RX, 16'h0000);
    idle(8);
    rd_chk(REG_SERVO_RX, 16'h00ff, 16'h00c3);
    wr(REG_SERVO_RX, 16'h0001);
    idle(8);
    rd_chk(REG_STATUS, 16'h0080, 16'h0080);
    user_address <= 3'h2;
    idle(8);
    cmp(thcp_link_if_inst.host_status_oe, 16'h0);
    cmp(thcp_link_if_inst.online_status_out, 16'h1);
    idle(2);
    cmp({15'h0, user_online}, 16'h0000);
    final_report();
  end
endmodule : tape_host_command_port_tb_top
`default_nettype wire

//--- verification/thcp_chk.sv
// concurrent checks on the link between the two ends
`timescale 1ns/1ns
`default_nettype none
module thcp_chk (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic online_status_out,
  input wire logic speed_status_out,
  input wire logic host_status_oe,
  input wire logic density_nrz_flag,
  input wire logic density_group_coded_flag,
  input wire logic density_3200_flag,
  input wire logic speed_select_flag,
  input wire logic data_processor_healthy,
  input wire logic servo_bus_dev_oe,
  input wire logic servo_link_write_strobe,
  input wire logic servo_link_read_strobe_a,
  input wire logic servo_link_read_strobe_b
);
  logic [3:0] mode;
  logic       rd;
  assign mode = {density_nrz_flag, density_group_coded_flag, density_3200_flag,
                 speed_select_flag};
  assign rd   = servo_link_read_strobe_a | servo_link_read_strobe_b;

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_b);

  chk_oe_online: assert property (host_status_oe |-> !online_status_out)
    else $error("status enabled while online line inactive");
  chk_strobe_excl: assert property (!(servo_link_write_strobe && rd))
    else $error("servo write and read strobes together");
  chk_wr_drive: assert property (servo_link_write_strobe |-> servo_bus_dev_oe)
    else $error("write strobe without device driving bus");
  chk_rd_release: assert property (rd |-> !servo_bus_dev_oe)
    else $error("device drives bus during read strobe");
  chk_mode_legal: assert property (mode inside {4'h8, 4'h9, 4'h0, 4'h1, 4'h2, 4'h4, 4'h5})
    else $error("unlisted mode code");
  chk_speed_line: assert property ($stable(mode) [*3] |->
      speed_status_out == !(speed_select_flag || density_3200_flag))
    else $error("speed status does not match mode lines");
  chk_wr_length: assert property ($rose(servo_link_write_strobe) |->
      servo_link_write_strobe [*3] ##1 !servo_link_write_strobe)
    else $error("servo write strobe not three cycles");
  chk_rd_length: assert property ($rose(rd) |-> rd [*3] ##1 !rd)
    else $error("servo read strobe not three cycles");
  chk_held_reset: assert property (!data_processor_healthy [*3] |->
      !servo_link_write_strobe && !rd)
    else $error("servo link active while not healthy");
endmodule : thcp_chk
`default_nettype wire
